// [hdl/wdt_map.svh]
// Register map, field positions, reset values and timing counts of the watchdog.
// Assumes inclusion by the package and the design files by bare name.
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define WDT_ADDR_CSR 16'hFFA8
`define WDT_ADDR_CNT 16'hFFA9
`define WDT_ADDR_WRITE 16'hFFA8
`define WDT_PW_CNT 8'h5A
`define WDT_PW_CSR 8'hA5
`define WDT_BIT_OVF 7
`define WDT_BIT_MODE 6
`define WDT_BIT_EN 5
`define WDT_BIT_RSV 4
`define WDT_BIT_RST 3
`define WDT_CSR_RESET 8'h10
`define WDT_CNT_RESET 8'h00
`define WDT_RESET_CYCLES 10'd518
`endif

// [hdl/wdt_pkg.sv]
// Types shared by the watchdog files.
// Assumes wdt_map.svh is on the include path.
`include "wdt_map.svh"
package wdt_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic word;
        logic [15:0] wdata;
    } bus_req_t;
    typedef struct packed {
        logic reset_req;
        logic nmi_req;
        logic ovf_irq;
        logic wdt_reset_cause;
    } wdt_event_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RESET} rst_state_t;
endpackage

// [hdl/wdt_prescaler.sv]
// Free-running divider giving one-cycle enable pulses at the eight counter rates.
// Assumes the system clock as the peripheral clock.
`timescale 1ns/100ps
module wdt_prescaler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [11:0] div_q;
    logic [11:0] mask;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= 12'h000;
        end else begin
            div_q <= div_q + 12'h001;
        end
    end

    always_comb begin
        case (sel)
            3'h0: mask = 12'h001;
            3'h1: mask = 12'h01F;
            3'h2: mask = 12'h03F;
            3'h3: mask = 12'h07F;
            3'h4: mask = 12'h0FF;
            3'h5: mask = 12'h1FF;
            3'h6: mask = 12'h7FF;
            default: mask = 12'hFFF;
        endcase
    end

    // Pulse when the low bits roll over
    assign tick = ((div_q & mask) == mask);
endmodule

// [hdl/wdt_top.sv]
// Watchdog / interval timer: counter, control/status, password writes, overflow actions.
// Assumes CPU byte reads and word writes on a simple strobe bus, and a standby entry pulse.
//
// Contract
// - 8-bit counter advances on selected tick when enabled
// - Counter wrap FF to 00 sets overflow flag
// - Counter zero at reset and while disabled
// - Flag clears by write 0 after read 1
// - Bit 6 selects interval or watchdog mode
// - Bit 3 selects NMI or chip reset
// - Bits 2-0 pick divider 2 to 4096
// - Reset/standby clear bits 7-5,3; 2-0 reset only
// - Only word writes update the registers
// - Upper byte password, lower byte data
// - Shared write address, password picks target
// - Byte reads at FFA8 status, FFA9 counter
// - Watchdog reset lasts 518 clocks, else NMI
// - Interval mode interrupts at every overflow
// - Flag set one cycle after the request
// - Watchdog reset flagged as reset cause
// - Counter write beats simultaneous increment
`timescale 1ns/100ps
`include "wdt_map.svh"
module wdt_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic standby_enter,
    input wdt_pkg::bus_req_t bus,
    output logic [7:0] rdata,
    output logic rvalid,
    output wdt_pkg::wdt_event_t events
);
    import wdt_pkg::*;

    logic [7:0] count_q;
    logic ovf_q;
    logic mode_q;
    logic en_q;
    logic rst_sel_q;
    logic [2:0] cks_q;
    logic ovf_seen_q;
    logic tick;
    logic wr_ok;
    logic wr_cnt;
    logic wr_csr;
    logic overflow;
    logic rd_csr;
    logic [7:0] csr_view;
    logic [9:0] rst_cnt_q;
    rst_state_t rst_state_q;
    logic reset_req;

    wdt_prescaler u_prescaler (
        .clk(clk),
        .rst_n(rst_n),
        .sel(cks_q),
        .tick(tick)
    );

    // Word write to the shared address only
    assign wr_ok = bus.wr && bus.word && (bus.addr == `WDT_ADDR_WRITE);
    assign wr_cnt = wr_ok && (bus.wdata[15:8] == `WDT_PW_CNT);
    assign wr_csr = wr_ok && (bus.wdata[15:8] == `WDT_PW_CSR);
    assign overflow = en_q && tick && !wr_cnt && (count_q == 8'hFF);
    assign rd_csr = bus.rd && (bus.addr == `WDT_ADDR_CSR);
    assign csr_view = {ovf_q, mode_q, en_q, 1'b1, rst_sel_q, cks_q};

    // Counter
    always_ff @(posedge clk) begin
        if (!rst_n || standby_enter) begin
            count_q <= `WDT_CNT_RESET;
        end else if (!en_q) begin
            count_q <= `WDT_CNT_RESET;
        end else if (wr_cnt) begin
            count_q <= bus.wdata[7:0];
        end else if (tick) begin
            count_q <= count_q + 8'h01;
        end
    end

    // Control bits cleared by reset and standby
    always_ff @(posedge clk) begin
        if (!rst_n || standby_enter) begin
            mode_q <= 1'b0;
            en_q <= 1'b0;
            rst_sel_q <= 1'b0;
        end else if (wr_csr) begin
            mode_q <= bus.wdata[`WDT_BIT_MODE];
            en_q <= bus.wdata[`WDT_BIT_EN];
            rst_sel_q <= bus.wdata[`WDT_BIT_RST];
        end
    end

    // Divider select survives standby
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cks_q <= 3'h0;
        end else if (wr_csr) begin
            cks_q <= bus.wdata[2:0];
        end
    end

    // Overflow flag; set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_n || standby_enter) begin
            ovf_q <= 1'b0;
            ovf_seen_q <= 1'b0;
        end else if (overflow) begin
            ovf_q <= 1'b1;
        end else if (wr_csr && !bus.wdata[`WDT_BIT_OVF] && ovf_seen_q) begin
            ovf_q <= 1'b0;
            ovf_seen_q <= 1'b0;
        end else if (rd_csr && ovf_q) begin
            ovf_seen_q <= 1'b1;
        end
    end

    // Read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= bus.rd;
            if (rd_csr) begin
                rdata <= csr_view;
            end else if (bus.rd && bus.addr == `WDT_ADDR_CNT) begin
                rdata <= count_q;
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    // Internal reset pulse of fixed length
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_state_q <= ST_IDLE;
            rst_cnt_q <= 10'd0;
        end else begin
            case (rst_state_q)
                ST_IDLE: begin
                    if (overflow && mode_q && rst_sel_q) begin
                        rst_state_q <= ST_RESET;
                        rst_cnt_q <= `WDT_RESET_CYCLES - 10'd2;
                    end
                end
                default: begin
                    if (rst_cnt_q == 10'd0) begin
                        rst_state_q <= ST_IDLE;
                    end else begin
                        rst_cnt_q <= rst_cnt_q - 10'd1;
                    end
                end
            endcase
        end
    end

    // Overflow cycle plus the counted cycles make up the whole pulse
    assign reset_req = (rst_state_q == ST_RESET) || (overflow && mode_q && rst_sel_q);

    // Length of the current internal reset pulse
    logic [9:0] rst_len_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_len_q <= 10'd0;
        end else if (reset_req) begin
            rst_len_q <= rst_len_q + 10'd1;
        end else begin
            rst_len_q <= 10'd0;
        end
    end

    // Counter read strobe
    logic rd_cnt;
    assign rd_cnt = bus.rd && (bus.addr == `WDT_ADDR_CNT);

    // Cause indicator holds until chip reset
    logic cause_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cause_q <= 1'b0;
        end else if (overflow && mode_q && rst_sel_q) begin
            cause_q <= 1'b1;
        end
    end

    always_comb begin
        events.reset_req = reset_req;
        events.nmi_req = overflow && mode_q && !rst_sel_q;
        events.ovf_irq = overflow && !mode_q;
        events.wdt_reset_cause = cause_q || reset_req;
    end

    // Assertions
    a_flag_on_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        overflow && !standby_enter |=> ovf_q) else $error("flag not set on wrap");
    a_zero_disabled: assert property (@(posedge clk) disable iff (!rst_n)
        !en_q |=> count_q == 8'h00) else $error("counter not held");
    a_byte_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        bus.wr && !bus.word && !en_q && !standby_enter |=> $stable(csr_view))
        else $error("byte write changed csr");
    a_reset_len: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(reset_req) |-> rst_len_q == `WDT_RESET_CYCLES) else $error("reset length wrong");
    a_reset_max: assert property (@(posedge clk) disable iff (!rst_n)
        rst_len_q <= `WDT_RESET_CYCLES) else $error("reset too long");
    a_reset_start: assert property (@(posedge clk) disable iff (!rst_n)
        overflow && mode_q && rst_sel_q |-> events.reset_req) else $error("reset not raised");
    a_reset_flag: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(events.reset_req) && !standby_enter |=> ovf_q) else $error("flag not set with reset");
    a_flag_with_req: assert property (@(posedge clk) disable iff (!rst_n)
        (events.nmi_req || events.ovf_irq) && !standby_enter |=> ovf_q) else $error("flag not set with request");
    a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        en_q && tick && !wr_cnt && !standby_enter |=> count_q == $past(count_q) + 8'h01)
        else $error("counter did not advance");
    a_count_hold: assert property (@(posedge clk) disable iff (!rst_n)
        en_q && !tick && !wr_cnt && !standby_enter |=> count_q == $past(count_q))
        else $error("counter moved without tick");
    a_wrap_zero: assert property (@(posedge clk) disable iff (!rst_n)
        overflow && !standby_enter |=> count_q == 8'h00) else $error("wrap not to zero");
    a_flag_needs_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        !overflow && !ovf_q |=> !ovf_q) else $error("flag set without wrap");
    a_clear_needs_read: assert property (@(posedge clk) disable iff (!rst_n)
        !overflow && ovf_q && !ovf_seen_q && !standby_enter |=> ovf_q) else $error("flag cleared unread");
    a_flag_write_clear: assert property (@(posedge clk) disable iff (!rst_n)
        wr_csr && !bus.wdata[`WDT_BIT_OVF] && ovf_seen_q && !overflow |=> !ovf_q)
        else $error("flag not cleared");
    a_seen_needs_flag: assert property (@(posedge clk) disable iff (!rst_n)
        ovf_seen_q |-> ovf_q) else $error("read mark without flag");
    a_mode_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_csr && !standby_enter |=> mode_q == $past(bus.wdata[`WDT_BIT_MODE])) else $error("mode not written");
    a_irq_nmi_excl: assert property (@(posedge clk) disable iff (!rst_n)
        !(events.ovf_irq && events.nmi_req)) else $error("both interrupt kinds");
    a_rst_select: assert property (@(posedge clk) disable iff (!rst_n)
        wr_csr && !standby_enter |=> rst_sel_q == $past(bus.wdata[`WDT_BIT_RST])) else $error("select not written");
    a_cks_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_csr |=> cks_q == $past(bus.wdata[2:0])) else $error("divider not written");
    a_standby_clear: assert property (@(posedge clk) disable iff (!rst_n)
        standby_enter |=> !mode_q && !en_q && !rst_sel_q && !ovf_q && count_q == 8'h00)
        else $error("standby did not clear");
    a_bad_write: assert property (@(posedge clk) disable iff (!rst_n)
        bus.wr && !wr_cnt && !wr_csr && !en_q && !standby_enter |=> $stable(csr_view) && count_q == 8'h00)
        else $error("refused write changed state");
    a_disabled_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_cnt && !en_q |=> count_q == 8'h00) else $error("write while stopped");
    a_read_count: assert property (@(posedge clk) disable iff (!rst_n)
        rvalid && $past(rd_cnt) |-> rdata == $past(count_q)) else $error("counter read wrong");
    a_read_csr: assert property (@(posedge clk) disable iff (!rst_n)
        rvalid && $past(rd_csr) |-> rdata == $past(csr_view)) else $error("status read wrong");
    a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        bus.rd |=> rvalid) else $error("read not answered");
    a_no_req_stopped: assert property (@(posedge clk) disable iff (!rst_n)
        !en_q |-> !events.ovf_irq && !events.nmi_req) else $error("request while stopped");
    a_cause_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        events.wdt_reset_cause |=> events.wdt_reset_cause) else $error("cause dropped");
    a_cause_with_reset: assert property (@(posedge clk) disable iff (!rst_n)
        events.reset_req |-> events.wdt_reset_cause) else $error("cause missing");
    a_nmi_mode: assert property (@(posedge clk) disable iff (!rst_n)
        events.nmi_req |-> mode_q && !rst_sel_q ##1 ovf_q || standby_enter) else $error("nmi bad");
    a_irq_interval: assert property (@(posedge clk) disable iff (!rst_n)
        events.ovf_irq |-> !mode_q && count_q == 8'hFF ##1 count_q == 8'h00) else $error("irq bad");
    a_write_wins: assert property (@(posedge clk) disable iff (!rst_n)
        wr_cnt && en_q && !standby_enter |=> count_q == $past(bus.wdata[7:0])) else $error("write lost");
    a_reserved_one: assert property (@(posedge clk) disable iff (!rst_n)
        rvalid && $past(rd_csr) |-> rdata[4]) else $error("reserved bit low");
    a_cks_standby: assert property (@(posedge clk) disable iff (!rst_n)
        standby_enter && !wr_csr |=> $stable(cks_q)) else $error("cks lost");
endmodule

// [tb/watchdog_interval_timer_bench.sv]
// Self-checking bench for the watchdog / interval timer top.
// Assumes wdt_map.svh, wdt_pkg and the design files are compiled first.
`timescale 1ns/100ps
`include "wdt_map.svh"
module watchdog_interval_timer_bench;
    import wdt_pkg::*;
    logic clk;
    logic rst_n;
    logic standby_enter;
    bus_req_t bus;
    logic [7:0] rdata;
    logic rvalid;
    wdt_event_t events;
    int miscompares;
    int n_checks;
    int cyc;
    int n;
    logic [7:0] v;
    logic [7:0] got;
    logic cause;

    wdt_top u_dut (.clk(clk), .rst_n(rst_n), .standby_enter(standby_enter), .bus(bus), .rdata(rdata),
        .rvalid(rvalid), .events(events));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic int div_of(input logic [2:0] c);
        int t[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
        return t[c];
    endfunction

    // Flag cannot be set by software; bit 4 always one
    function automatic logic [7:0] csr_exp(input logic [7:0] d);
        return {1'b0, d[6:5], 1'b1, d[3:0]};
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] pw, input logic [7:0] d, input logic word);
        @(posedge clk);
        bus <= '{addr: `WDT_ADDR_WRITE, wr: 1'b1, rd: 1'b0, word: word, wdata: {pw, d}};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk({7'h00, rvalid}, 8'h01);
        d = rdata;
    endtask

    // Waits for a request bit, then checks all three request lines together
    task automatic wait_ev(input int b, input logic [2:0] e);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (events[b] !== 1'b1 && n < 2000);
        chk({5'h00, events[3:1]}, {5'h00, e});
    endtask

    task automatic wrap_up;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 45000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        rst_n = 1'b0;
        standby_enter = 1'b0;
        bus = '0;
        void'($urandom(32'h912C));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(`WDT_ADDR_CSR, got); chk(got, 8'h10);
        rd(`WDT_ADDR_CNT, got); chk(got, 8'h00);
        rd(16'hFF00, got); chk(got, 8'h00);
        $display("test reset values done");
        for (int c = 0; c < 8; c++) begin
            wr(8'hA5, 8'h00, 1'b1);
            v = $urandom;
            v[6:5] = 2'b01;
            v[2:0] = c[2:0];
            wr(8'hA5, v, 1'b1);
            rd(`WDT_ADDR_CSR, got); chk(got, csr_exp(v));
            repeat (4 * div_of(v[2:0])) @(posedge clk);
            rd(`WDT_ADDR_CNT, got); chk({7'h00, got >= 8'h03 && got <= 8'h06}, 8'h01);
        end
        $display("test divider codes done");
        wr(8'hA5, 8'h00, 1'b0);
        wr(8'h3C, 8'h00, 1'b1);
        wr(8'h5A, 8'h77, 1'b0);
        rd(`WDT_ADDR_CSR, got); chk(got, csr_exp(v));
        rd(`WDT_ADDR_CNT, got); chk({7'h00, got < 8'h10}, 8'h01);
        v = $urandom;
        wr(8'h5A, v, 1'b1);
        rd(`WDT_ADDR_CNT, got); chk(got, v);
        $display("test password writes done");
        wr(8'hA5, 8'h20, 1'b1);
        wr(8'h5A, 8'hFE, 1'b1);
        wait_ev(1, 3'b001);
        wait_ev(1, 3'b001); chk(n[7:0], 8'h00);
        chk({7'h00, n == 512}, 8'h01);
        rd(`WDT_ADDR_CSR, got); chk(got, 8'hB0);
        wr(8'hA5, 8'h20, 1'b1);
        rd(`WDT_ADDR_CSR, got); chk(got, 8'h30);
        $display("test interval mode done");
        wr(8'hA5, 8'h60, 1'b1);
        wr(8'h5A, 8'hFE, 1'b1);
        wait_ev(2, 3'b010);
        wr(8'hA5, 8'h69, 1'b1);
        wr(8'h5A, 8'hFE, 1'b1);
        wait_ev(3, 3'b100);
        n = 0;
        while (events.reset_req === 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk({7'h00, n == 518}, 8'h01);
        chk({7'h00, events.wdt_reset_cause}, 8'h01);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(`WDT_ADDR_CSR, got); chk(got, 8'h10);
        chk({7'h00, events.wdt_reset_cause}, 8'h00);
        $display("test watchdog mode done");
        wr(8'hA5, 8'h6D, 1'b1);
        @(posedge clk);
        standby_enter <= 1'b1;
        @(posedge clk);
        standby_enter <= 1'b0;
        rd(`WDT_ADDR_CSR, got); chk(got, 8'h15);
        rd(`WDT_ADDR_CNT, got); chk(got, 8'h00);
        $display("test standby done");
        wrap_up();
    end
endmodule
